// [core/irq_defines.svh]
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH
`define OFS_ENABLE_MAIN 8'hA8
`define OFS_PRIO_HIGH 8'hB7
`define OFS_PRIO_LOW 8'hB8
`define OFS_ENABLE_EXT 8'hE8
`define OFS_EVT_STATUS 8'hC0
`define OFS_EVT_MASK 8'hC1
`define OFS_ACTIVE 8'hC2
`define RST_REG 8'h00
`define BIT_GLOBAL 7
`define BIT_EXT0 0
`define BIT_T0 1
`define BIT_EXT1 2
`define BIT_T1 3
`define BIT_SER 4
`define BIT_BOD 5
`define BIT_ADC 6
`define BIT_CAP 7
`define EXT_CAP_BIT 2
`define NUM_SRC 8
`endif

// [core/irq_pkg.sv]
package irq_pkg;
    typedef logic [1:0] level_t;
    typedef enum logic [1:0] {CMD_NONE, CMD_TAKE, CMD_DONE} cmd_t;
endpackage

// [core/prio_pick.sv]
`timescale 1ns/1ps
`include "irq_defines.svh"
module prio_pick
    import irq_pkg::*;
#(
    parameter int N = 8
)
(
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] prio_lo,
    input wire logic [N-1:0] prio_hi,
    output logic found,
    output logic [2:0] idx,
    output level_t level
);
    // ranking over the eight main-bank sources, best first
    localparam logic [2:0] RANK [0:7] = '{3'h0, 3'h5, 3'h1, 3'h6, 3'h2, 3'h3, 3'h4, 3'h7};

    always_comb
    begin
        found = 1'b0;
        idx = 3'h0;
        level = 2'h0;
        for (int l = 3; l >= 0; l--)
        begin
            for (int r = 0; r < 8; r++)
            begin
                if (!found && req[RANK[r]]
                    && {prio_hi[RANK[r]], prio_lo[RANK[r]]} == 2'(l))
                begin
                    found = 1'b1;
                    idx = RANK[r];
                    level = 2'(l);
                end
            end
        end
    end
endmodule

// [core/irq_enable_priority_bank.sv]
`timescale 1ns/1ps
`include "irq_defines.svh"
module irq_enable_priority_bank
    import irq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext0_pin,
    input wire logic ext1_pin,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic serial_tx_done,
    input wire logic serial_rx_done,
    input wire logic brownout_flag,
    input wire logic converter_flag,
    input wire logic capture_flag,
    input wire logic irq_take,
    input wire logic irq_done,
    output logic irq_req,
    output logic [2:0] irq_src,
    output level_t irq_level,
    output logic irq_out
);
    logic [7:0] irq_enable_main_q;
    logic [7:0] irq_enable_extended_q;
    logic [7:0] irq_prio_high_main_q;
    logic [7:0] irq_prio_low_main_q;
    logic [7:0] evt_status_q;
    logic [7:0] evt_mask_q;
    logic [3:0] active_q;
    logic ext0_s1_q;
    logic ext0_s2_q;
    logic ext1_s1_q;
    logic ext1_s2_q;
    logic [7:0] raw;
    logic [7:0] gated;
    logic found;
    logic [2:0] pick_idx;
    level_t pick_lvl;
    logic [1:0] cur_lvl;
    logic any_active;
    logic preempt_ok;

    // pins are asynchronous; two stages before use
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ext0_s1_q <= 1'b0;
            ext0_s2_q <= 1'b0;
            ext1_s1_q <= 1'b0;
            ext1_s2_q <= 1'b0;
        end
        else
        begin
            ext0_s1_q <= ext0_pin;
            ext0_s2_q <= ext0_s1_q;
            ext1_s1_q <= ext1_pin;
            ext1_s2_q <= ext1_s1_q;
        end
    end

    always_comb
    begin
        raw = 8'h00;
        raw[`BIT_EXT0] = ext0_s2_q;
        raw[`BIT_T0] = timer0_overflow;
        raw[`BIT_EXT1] = ext1_s2_q;
        raw[`BIT_T1] = timer1_overflow;
        raw[`BIT_SER] = serial_tx_done | serial_rx_done;
        raw[`BIT_BOD] = brownout_flag;
        raw[`BIT_ADC] = converter_flag;
        raw[`BIT_CAP] = capture_flag;
    end

    generate
        for (genvar i = 0; i < `NUM_SRC; i++)
        begin : g_gate
            logic own_gate;
            // capture takes its gate from the extended register
            if (i == `BIT_CAP)
            begin : g_cap
                assign own_gate = irq_enable_extended_q[`EXT_CAP_BIT];
            end
            else
            begin : g_main
                assign own_gate = irq_enable_main_q[i];
            end
            assign gated[i] = irq_enable_main_q[`BIT_GLOBAL] & own_gate & raw[i];
        end
    endgenerate

    prio_pick #(.N(8)) u_pick (
        .req(gated),
        .prio_lo(irq_prio_low_main_q),
        .prio_hi(irq_prio_high_main_q),
        .found(found),
        .idx(pick_idx),
        .level(pick_lvl)
    );

    // active_q holds one in-service bit per level
    always_comb
    begin
        cur_lvl = 2'h0;
        any_active = |active_q;
        for (int l = 0; l < 4; l++)
        begin
            if (active_q[l])
            begin
                cur_lvl = 2'(l);
            end
        end
    end

    assign preempt_ok = !any_active || (pick_lvl > cur_lvl);
    assign irq_req = found && preempt_ok;
    assign irq_src = pick_idx;
    assign irq_level = pick_lvl;

    // done clears the top in-service level before take marks the offered one
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            active_q <= 4'h0;
        end
        else
        begin
            if (irq_done && any_active)
            begin
                active_q[cur_lvl] <= 1'b0;
            end
            if (irq_take && irq_req)
            begin
                active_q[pick_lvl] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_enable_main_q <= `RST_REG;
        end
        else if (reg_wr && reg_addr == `OFS_ENABLE_MAIN)
        begin
            irq_enable_main_q <= reg_wdata;
        end
    end

    // bit 3 is reserved and always reads zero
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_enable_extended_q <= `RST_REG;
        end
        else if (reg_wr && reg_addr == `OFS_ENABLE_EXT)
        begin
            irq_enable_extended_q <= reg_wdata & 8'hF7;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_prio_high_main_q <= `RST_REG;
        end
        else if (reg_wr && reg_addr == `OFS_PRIO_HIGH)
        begin
            irq_prio_high_main_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_prio_low_main_q <= `RST_REG;
        end
        else if (reg_wr && reg_addr == `OFS_PRIO_LOW)
        begin
            irq_prio_low_main_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            evt_mask_q <= `RST_REG;
        end
        else if (reg_wr && reg_addr == `OFS_EVT_MASK)
        begin
            evt_mask_q <= reg_wdata;
        end
    end

    // sticky per-source events of gated requests; set wins over write-one clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            evt_status_q <= `RST_REG;
        end
        else
        begin
            evt_status_q <= ((reg_wr && reg_addr == `OFS_EVT_STATUS)
                ? (evt_status_q & ~reg_wdata) : evt_status_q) | gated;
        end
    end

    assign irq_out = |(evt_status_q & evt_mask_q);

    // read data stand for the one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == `OFS_ENABLE_MAIN)
            begin
                reg_rdata <= irq_enable_main_q;
            end
            else if (reg_addr == `OFS_ENABLE_EXT)
            begin
                reg_rdata <= irq_enable_extended_q;
            end
            else if (reg_addr == `OFS_PRIO_HIGH)
            begin
                reg_rdata <= irq_prio_high_main_q;
            end
            else if (reg_addr == `OFS_PRIO_LOW)
            begin
                reg_rdata <= irq_prio_low_main_q;
            end
            else if (reg_addr == `OFS_EVT_STATUS)
            begin
                reg_rdata <= evt_status_q;
            end
            else if (reg_addr == `OFS_EVT_MASK)
            begin
                reg_rdata <= evt_mask_q;
            end
            else if (reg_addr == `OFS_ACTIVE)
            begin
                reg_rdata <= {4'h0, active_q};
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

    chk_global_gate_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !irq_enable_main_q[`BIT_GLOBAL] |-> !irq_req)
        else $error("request while global gate clear");

    chk_source_needs_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_req && irq_src != 3'h7 |-> irq_enable_main_q[irq_src])
        else $error("request from ungated source");

    chk_capture_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        gated[`BIT_CAP] |-> irq_enable_extended_q[`EXT_CAP_BIT] && capture_flag)
        else $error("capture passed while gated off");

    chk_serial_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !irq_enable_main_q[`BIT_SER] |-> !gated[`BIT_SER])
        else $error("serial passed while gated off");

    chk_serial_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_enable_main_q[`BIT_GLOBAL] && irq_enable_main_q[`BIT_SER]
            && (serial_tx_done || serial_rx_done) |-> gated[`BIT_SER])
        else $error("serial request not passed");

    chk_timer1_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        gated[`BIT_T1] |-> irq_enable_main_q[`BIT_T1] && timer1_overflow)
        else $error("timer 1 gate wrong");

    chk_ext1_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        gated[`BIT_EXT1] |-> irq_enable_main_q[`BIT_EXT1] && $past(ext1_pin, 2))
        else $error("ext 1 gate wrong");

    chk_timer0_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        gated[`BIT_T0] |-> irq_enable_main_q[`BIT_T0])
        else $error("timer 0 gate wrong");

    chk_ext0_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        gated[`BIT_EXT0] |-> irq_enable_main_q[`BIT_EXT0])
        else $error("ext 0 gate wrong");

    chk_level_encoding: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_req |-> irq_level == {irq_prio_high_main_q[irq_src],
            irq_prio_low_main_q[irq_src]})
        else $error("level not hi,lo of source");

    chk_preempt_higher: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_req && any_active |-> irq_level > cur_lvl)
        else $error("preempt by equal or lower level");

    chk_take_sets_active: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_take && irq_req |=> active_q[$past(pick_lvl)])
        else $error("taken level not marked in service");

    chk_done_clears_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_done && any_active && !irq_take |=> !active_q[$past(cur_lvl)])
        else $error("done left top level in service");

    chk_ext0_wins_tie: assert property (@(posedge clk_sys) disable iff (!rst_n)
        found && gated[`BIT_EXT0] && {irq_prio_high_main_q[0], irq_prio_low_main_q[0]} == 2'h3
        |-> pick_idx == 3'h0)
        else $error("ext 0 lost top-level tie");

    chk_reset_clear: assert property (@(posedge clk_sys)
        !rst_n |=> irq_enable_main_q == 8'h00 && irq_prio_high_main_q == 8'h00)
        else $error("registers not cleared by reset");

    chk_ext_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !irq_enable_extended_q[3])
        else $error("reserved extended enable bit set");

    chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");

    chk_status_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(reg_wr && reg_addr == `OFS_EVT_STATUS)
            |=> (evt_status_q & $past(evt_status_q)) == $past(evt_status_q))
        else $error("event status bit lost without clear");
endmodule

// [testbench/cpu_model.sv]
`timescale 1ns/1ps
module cpu_model
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic irq_req,
    input wire logic take_cmd,
    input wire logic done_cmd,
    output logic irq_take,
    output logic irq_done
);
    logic armed_q;
    // once armed, accept the next request the block offers, one pulse only
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            armed_q <= 1'b0;
            irq_take <= 1'b0;
            irq_done <= 1'b0;
        end
        else
        begin
            irq_take <= armed_q && irq_req;
            if (take_cmd)
                armed_q <= 1'b1;
            else if (irq_req)
                armed_q <= 1'b0;
            irq_done <= done_cmd;
        end
    end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`include "irq_defines.svh"
module tb_top import irq_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] flags = 8'h00;
    logic rx = 1'b0;
    logic take_cmd = 1'b0;
    logic done_cmd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq_take;
    logic irq_done;
    logic irq_req;
    logic irq_out;
    logic [2:0] irq_src;
    level_t irq_level;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] ofs [4] = '{`OFS_ENABLE_MAIN, `OFS_PRIO_HIGH, `OFS_PRIO_LOW, `OFS_ENABLE_EXT};
    logic [7:0] all_ones [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hF7};

    always #12.5 clk_sys = ~clk_sys;

    irq_enable_priority_bank irq_enable_priority_bank_i (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ext0_pin(flags[0]), .timer0_overflow(flags[1]), .ext1_pin(flags[2]),
        .timer1_overflow(flags[3]), .serial_tx_done(flags[4]), .serial_rx_done(rx),
        .brownout_flag(flags[5]), .converter_flag(flags[6]), .capture_flag(flags[7]),
        .irq_take, .irq_done, .irq_req, .irq_src, .irq_level, .irq_out);

    cpu_model cpu_model_i (.clk_sys, .rst_n, .irq_req, .take_cmd, .done_cmd, .irq_take,
        .irq_done);

    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // packs {req, level, 00, source}; source and level are ignored with no request
    task automatic req_chk(input logic [7:0] e);
        chk(irq_req === 1'b1 ? {irq_req, irq_level, 2'h0, irq_src} : {7'h0, irq_req}, e);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    // three edges cover the two-flop synchroniser on the pins
    task automatic set_src(input logic [7:0] f);
        @(posedge clk_sys);
        flags <= f;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse(input logic t, input logic d);
        @(posedge clk_sys);
        take_cmd <= t;
        done_cmd <= d;
        @(posedge clk_sys);
        take_cmd <= 1'b0;
        done_cmd <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            stop_test();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        req_chk(8'h00);
        for (int i = 0; i < 4; i++)
        begin
            rd_chk(ofs[i], 8'h00);
            wr_reg(ofs[i], 8'hFF);
            rd_chk(ofs[i], all_ones[i]);
            wr_reg(ofs[i], 8'h00);
        end
        wr_reg(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 5; i++)
        begin
            set_src(8'h01 << i);
            wr_reg(`OFS_ENABLE_MAIN, 8'h01 << i);
            req_chk(8'h00);
            wr_reg(`OFS_ENABLE_MAIN, 8'h80);
            req_chk(8'h00);
            wr_reg(`OFS_ENABLE_MAIN, 8'h80 | (8'h01 << i));
            req_chk(8'h80 | 8'(i));
        end
        set_src(8'h00);
        @(posedge clk_sys);
        rx <= 1'b1;
        @(posedge clk_sys);
        #1;
        req_chk(8'h84);
        wr_reg(`OFS_ENABLE_MAIN, 8'h80);
        req_chk(8'h00);
        @(posedge clk_sys);
        rx <= 1'b0;
        $display("test gating done");
        set_src(8'h09);
        wr_reg(`OFS_ENABLE_MAIN, 8'h89);
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(`OFS_PRIO_HIGH, 8'(k / 2) << 3);
            wr_reg(`OFS_PRIO_LOW, 8'(k % 2) << 3);
            req_chk(k == 0 ? 8'h80 : {1'b1, 2'(k), 5'h03});
        end
        set_src(8'h80);
        wr_reg(`OFS_ENABLE_EXT, 8'h04);
        wr_reg(`OFS_ENABLE_MAIN, 8'h80);
        wr_reg(`OFS_PRIO_HIGH, 8'h80);
        wr_reg(`OFS_PRIO_LOW, 8'h00);
        req_chk(8'hC7);
        wr_reg(`OFS_ENABLE_EXT, 8'h00);
        req_chk(8'h00);
        $display("test priority done");
        set_src(8'h09);
        wr_reg(`OFS_ENABLE_MAIN, 8'h89);
        wr_reg(`OFS_PRIO_HIGH, 8'h08);
        wr_reg(`OFS_PRIO_LOW, 8'h01);
        req_chk(8'hC3);
        pulse(1'b1, 1'b0);
        rd_chk(`OFS_ACTIVE, 8'h04);
        req_chk(8'h00);
        wr_reg(`OFS_PRIO_HIGH, 8'h09);
        req_chk(8'hE0);
        pulse(1'b0, 1'b1);
        rd_chk(`OFS_ACTIVE, 8'h00);
        $display("test preemption done");
        wr_reg(`OFS_ENABLE_MAIN, 8'h81);
        wr_reg(`OFS_EVT_MASK, 8'h00);
        set_src(8'h00);
        wr_reg(`OFS_EVT_STATUS, 8'hFF);
        rd_chk(`OFS_EVT_STATUS, 8'h00);
        set_src(8'h01);
        rd_chk(`OFS_EVT_STATUS, 8'h01);
        chk({7'h0, irq_out}, 8'h00);
        wr_reg(`OFS_EVT_MASK, 8'h01);
        chk({7'h0, irq_out}, 8'h01);
        set_src(8'h00);
        wr_reg(`OFS_EVT_STATUS, 8'h01);
        chk({7'h0, irq_out}, 8'h00);
        rd_chk(`OFS_EVT_STATUS, 8'h00);
        $display("test events done");
        stop_test();
    end
endmodule
